// File: src/iec_top.sv
// Purpose: Input filtering, edge interrupts with delay, pulse catch, counter checks
// Assumes: Inputs are asynchronous pins; AHB-Lite slave with zero wait states
// Notes:   Delay words sit at their own offsets, one per interrupt input (0-5)
// Function
// RULE1: six inputs each raise their own interrupt to the program
// RULE2: source holds each interrupt input level at least 5 us
// RULE3: separate rise and fall vectors per input, plus a disable flag
// RULE4: service start is postponed by a programmable count of 1 ms steps
// RULE5: eight catch flags latch when an ON pulse is seen
// RULE6: catch pulses last 5 us on inputs 0-5, 50 us on 6-7
// RULE7: counter inputs get 5 us filter (0-5) or 50 us (6-7)
// RULE8: other inputs keep a 10 ms filter after reset
// RULE9: indexed compare addressing switches all counters to software mode
// RULE10: optional counters flag inputs at 10 kHz or faster
// RULE11: configuration gives each fast input only one function
// RULE12: source keeps counter rates within the allowed response frequency
// RULE13: weighted sum of counter frequencies is checked against the overall limit
// RULE14: a watchdog error forces all outputs off
// RULE15: inputs are synchronised before edge detection
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module iec_top
  import iec_pkg::*;
#(
  parameter int unsigned DEF_CYC  = iec_pkg::DEF_FILT_CYC,
  parameter int unsigned STEP_LEN = iec_pkg::STEP_CYC
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // Input terminals
  input  wire logic [7:0]           in_pin,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Events and status
  input  wire iec_pkg::iec_freq_t   freq_in,
  output logic                      irq,
  output logic [5:0]                in_rise_vector,
  output logic [5:0]                in_fall_vector,
  output logic [7:0]                catch_flag,
  output logic                      soft_count_mode,
  output logic                      outputs_off
);
  import iec_pkg::*;

  logic [7:0]  s1_r, s2_r, s3_r, filt_r;
  logic [31:0] status_r, status_set;
  logic [31:0] mask_r, irqdis_r, control_r;
  logic [7:0]  hscsel_r;
  logic [7:0]  catch_r;
  logic        wdt_r;
  iec_req_t    req_r;
  logic [2:0]  dly_idx_r;
  logic [7:0]  dly_rd;
  logic [5:0]  pend_r, rise_pend_r;
  logic [5:0]  rise_ev, fall_ev;
  logic [7:0]  rise_all;
  logic [23:0] step_cnt_r;
  logic        step_tick;
  logic        freq_err, opt_err;
  logic        rd_status;

  // Three-stage synchroniser
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end
    else
    begin
      s1_r <= in_pin;    // RULE15
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Per-input filter and edge detection
  logic [31:0] fcnt_r [8];
  logic [31:0] opt_cnt_r [2];
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_in
      logic [31:0] lim;
      logic        agree;
      assign agree = (s2_r[g] == s3_r[g]);
      always_comb
      begin
        if (hscsel_r[g])
          lim = (g < 6) ? FAST_FILT_CYC : SLOW_FILT_CYC;   // RULE7
        else
          lim = DEF_CYC;                                   // RULE8
      end
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          fcnt_r[g] <= 32'h0000_0000;
          filt_r[g] <= 1'b0;
        end
        else if (!agree || (s3_r[g] == filt_r[g]))
          fcnt_r[g] <= 32'h0000_0000;
        else if (fcnt_r[g] + 32'h0000_0001 >= lim)
        begin
          fcnt_r[g] <= 32'h0000_0000;
          filt_r[g] <= s3_r[g];                            // RULE15
        end
        else
          fcnt_r[g] <= fcnt_r[g] + 32'h0000_0001;
      end
    end
  endgenerate

  // Filtered edges
  logic [7:0] filt_d_r;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      filt_d_r <= 8'h00;
    else
      filt_d_r <= filt_r;
  end
  assign rise_all = filt_r & ~filt_d_r;
  assign rise_ev  = rise_all[5:0] & ~irqdis_r[5:0];              // RULE3
  assign fall_ev  = ~filt_r[5:0] & filt_d_r[5:0] & ~irqdis_r[5:0]; // RULE3

  // Millisecond step tick
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      step_cnt_r <= 24'h00_0000;
    else if (step_cnt_r >= 24'(STEP_LEN - 1))
      step_cnt_r <= 24'h00_0000;
    else
      step_cnt_r <= step_cnt_r + 24'h00_0001;
  end
  assign step_tick = (step_cnt_r >= 24'(STEP_LEN - 1));

  // Delay settings memory, read rotates over the six inputs
  iec_delay_mem #(.DEPTH(6), .AW(3), .DW(8)) u_dly (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_en   (req_r.sel && req_r.write && (req_r.addr[7:5] == OFF_DELAY[7:5])
              && (req_r.addr[4:2] < 3'h6)),
    .wr_addr (req_r.addr[4:2]),
    .wr_data (hwdata[7:0]),
    .rd_addr (dly_idx_r),
    .rd_data (dly_rd)
  );

  // Per-input delay countdown
  logic [7:0] dly_val_r [6];
  logic [7:0] dwn_r [6];
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      dly_idx_r <= 3'h0;
    else
      dly_idx_r <= (dly_idx_r == 3'h5) ? 3'h0 : dly_idx_r + 3'h1;
  end
  logic [2:0] dly_idx_d_r;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      dly_idx_d_r <= 3'h0;
    else
      dly_idx_d_r <= dly_idx_r;
  end

  generate
    for (g = 0; g < 6; g++)
    begin : g_irq
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
          dly_val_r[g] <= RST_DELAY;
        else if (dly_idx_d_r == 3'(g))
          dly_val_r[g] <= dly_rd;
      end
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          pend_r[g]      <= 1'b0;
          rise_pend_r[g] <= 1'b0;
          dwn_r[g]       <= 8'h00;
        end
        else if (rise_ev[g] || fall_ev[g])
        begin
          pend_r[g]      <= 1'b1;                          // RULE4
          rise_pend_r[g] <= rise_ev[g];
          dwn_r[g]       <= dly_val_r[g];
        end
        else if (pend_r[g] && dwn_r[g] == 8'h00)
          pend_r[g] <= 1'b0;
        else if (pend_r[g] && step_tick)
          dwn_r[g] <= dwn_r[g] - 8'h01;                    // RULE4
      end
      assign status_set[ST_RISE+g] = pend_r[g] && dwn_r[g] == 8'h00 && rise_pend_r[g]; // RULE1
      assign status_set[ST_FALL+g] = pend_r[g] && dwn_r[g] == 8'h00 && !rise_pend_r[g];
    end
  endgenerate
  assign status_set[7:6]   = 2'b00;
  assign status_set[15:14] = 2'b00;
  assign status_set[ST_CAT+7:ST_CAT] = rise_all;           // RULE5
  assign status_set[ST_FRQ] = freq_err;
  assign status_set[ST_OPT] = opt_err;
  assign status_set[31:26] = 6'h00;

  // Optional counter rate watch on inputs 6 and 7
  logic [1:0] opt_err_v;
  generate
    for (g = 0; g < 2; g++)
    begin : g_opt
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
          opt_cnt_r[g] <= 32'h0000_0000;
        else if (rise_all[6+g])
          opt_cnt_r[g] <= 32'h0000_0000;
        else if (opt_cnt_r[g] != 32'hFFFF_FFFF)
          opt_cnt_r[g] <= opt_cnt_r[g] + 32'h0000_0001;
      end
      assign opt_err_v[g] = hscsel_r[6+g] && rise_all[6+g]
                            && (opt_cnt_r[g] < OPT_MIN_CYC); // RULE10
    end
  endgenerate
  assign opt_err  = |opt_err_v;
  assign freq_err = (freq_in.total > freq_in.limit);       // RULE13

  // Catch flags, set wins over a read clear
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      catch_r <= 8'h00;
    else if (req_r.sel && !req_r.write && req_r.addr == OFF_CATCH)
      catch_r <= rise_all;                                 // RULE5
    else
      catch_r <= catch_r | rise_all;                       // RULE5
  end

  // AHB-Lite address phase capture
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      req_r <= '0;
    else if (hready)
    begin
      req_r.sel   <= hsel && htrans[1];
      req_r.write <= hwrite;
      req_r.addr  <= haddr[7:0];
    end
    else
      req_r.sel <= 1'b0;
  end
  assign rd_status = req_r.sel && !req_r.write && req_r.addr == OFF_STATUS;

  // Software registers
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mask_r    <= RST_MASK;
      irqdis_r  <= RST_IRQDIS;
      hscsel_r  <= 8'h00;
      control_r <= 32'h0000_0000;
    end
    else if (req_r.sel && req_r.write)
    begin
      if (req_r.addr == OFF_MASK)
        mask_r <= hwdata;
      else if (req_r.addr == OFF_IRQDIS)
        irqdis_r <= {26'h000_0000, hwdata[5:0]};           // RULE3
      else if (req_r.addr == OFF_HSCSEL)
        hscsel_r <= hwdata[7:0];
      else if (req_r.addr == OFF_CONTROL)
        control_r <= {30'h0000_0000, hwdata[1:0]};
    end
  end

  // Sticky status, cleared by read, set wins
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      status_r <= 32'h0000_0000;
    else if (rd_status)
      status_r <= status_set;
    else
      status_r <= status_r | status_set;
  end

  // Watchdog error latch
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      wdt_r <= 1'b0;
    else if (control_r[CT_WDT])
      wdt_r <= 1'b1;
  end

  // Read data
  always_comb
  begin
    if (req_r.addr == OFF_STATUS)
      hrdata = status_r;
    else if (req_r.addr == OFF_MASK)
      hrdata = mask_r;
    else if (req_r.addr == OFF_CATCH)
      hrdata = {24'h00_0000, catch_r};
    else if (req_r.addr == OFF_IRQDIS)
      hrdata = irqdis_r;
    else if (req_r.addr == OFF_HSCSEL)
      hrdata = {24'h00_0000, hscsel_r};
    else if (req_r.addr == OFF_CONTROL)
      hrdata = control_r;
    else if (req_r.addr == OFF_FREQ)
      hrdata = {freq_in.limit, freq_in.total};
    else if (req_r.addr == OFF_PINS)
      hrdata = {24'h00_0000, filt_r};
    else
      hrdata = 32'h0000_0000;
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Outputs; irq, rise and fall vectors and catch flags forced off on watchdog error
  assign outputs_off     = wdt_r;
  assign soft_count_mode = control_r[CT_INDEXED];                        // RULE9
  assign irq             = !wdt_r && |(status_r & mask_r);              // RULE14
  assign in_rise_vector  = wdt_r ? 6'h00 : status_r[ST_RISE+5:ST_RISE]; // RULE14
  assign in_fall_vector  = wdt_r ? 6'h00 : status_r[ST_FALL+5:ST_FALL];
  assign catch_flag      = wdt_r ? 8'h00 : catch_r;                      // RULE14

  // Assertions
  catch_sticky_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    rise_all[0] |=> catch_r[0])                                          // RULE5
    else $error("catch flag not set on pulse");
  dis_blocks_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    irqdis_r[0] |-> !rise_ev[0] && !fall_ev[0])                          // RULE3
    else $error("disabled input raised event");
  wdt_off_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    wdt_r |-> !irq && catch_flag == 8'h00)                               // RULE14
    else $error("outputs not off after watchdog");
  soft_mode_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(control_r[CT_INDEXED]) |-> soft_count_mode)                    // RULE9
    else $error("software counter mode missing");
  freq_flag_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    freq_err && !rd_status |=> status_r[ST_FRQ])                         // RULE13
    else $error("frequency error not flagged");
  sync_edge_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    rise_all[1] |=> !rise_all[1])                                        // RULE15
    else $error("edge event longer than one cycle");
  fast_filter_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    hscsel_r[0] && $changed(filt_r[0]) |-> $past(s3_r[0], 1) == filt_r[0]) // RULE7
    else $error("filter took wrong value");
  delay_zero_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    rise_ev[2] && dly_val_r[2] == 8'h00 |=> status_set[ST_RISE+2])       // RULE4
    else $error("zero delay not immediate");
  irq_out_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    (status_r & mask_r) != 32'h0 && !wdt_r |-> irq)                      // RULE1
    else $error("interrupt not raised");
  def_filter_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    !hscsel_r[3] && $changed(filt_r[3]) |-> $past(fcnt_r[3]) + 1 >= DEF_CYC) // RULE8
    else $error("default filter too short");
  opt_rate_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
    opt_err |=> status_r[ST_OPT])                                        // RULE10
    else $error("optional counter rate not flagged");
endmodule
`default_nettype wire

// File: src/iec_pkg.sv
// Purpose: Shared constants and types for the input edge event capture block
// Assumes: 125 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   Times are given in their own unit, cycle counts derive from them
package iec_pkg;

  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned FAST_FILT_NS  = 5000;
  localparam int unsigned SLOW_FILT_NS  = 50000;
  localparam int unsigned DEF_FILT_MS   = 10;
  localparam int unsigned DELAY_STEP_MS = 1;
  localparam int unsigned OPT_MAX_KHZ   = 10;
  localparam int unsigned FAST_FILT_CYC = (FAST_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLOW_FILT_CYC = (SLOW_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DEF_FILT_CYC  = DEF_FILT_MS * 1000 * CLK_MHZ;
  localparam int unsigned STEP_CYC      = DELAY_STEP_MS * 1000 * CLK_MHZ;
  // Shortest legal period of an optional counter input, in cycles
  localparam int unsigned OPT_MIN_CYC   = (1000 * CLK_MHZ) / OPT_MAX_KHZ;

  localparam int unsigned N_IN  = 8;
  localparam int unsigned N_IRQ = 6;

  // Register byte offsets
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_MASK     = 8'h04;
  localparam logic [7:0] OFF_CATCH    = 8'h08;
  localparam logic [7:0] OFF_IRQDIS   = 8'h0C;
  localparam logic [7:0] OFF_DELAY    = 8'h40;  // Six words, one per interrupt input
  localparam logic [7:0] OFF_HSCSEL   = 8'h14;
  localparam logic [7:0] OFF_CONTROL  = 8'h18;
  localparam logic [7:0] OFF_FREQ     = 8'h1C;
  localparam logic [7:0] OFF_PINS     = 8'h20;

  // Status bit positions: 0..5 rise, 8..13 fall, 16..23 catch, 24 freq, 25 opt rate
  localparam int unsigned ST_RISE = 0;
  localparam int unsigned ST_FALL = 8;
  localparam int unsigned ST_CAT  = 16;
  localparam int unsigned ST_FRQ  = 24;
  localparam int unsigned ST_OPT  = 25;

  // Control bits
  localparam int unsigned CT_INDEXED = 0;
  localparam int unsigned CT_WDT     = 1;

  localparam logic [31:0] RST_MASK   = 32'h0000_0000;
  localparam logic [31:0] RST_IRQDIS = 32'h0000_003F;
  localparam logic [7:0]  RST_DELAY  = 8'h00;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } iec_req_t;

  typedef struct packed {
    logic [15:0] total;
    logic [15:0] limit;
  } iec_freq_t;

endpackage

// File: src/iec_delay_mem.sv
// Purpose: Per-interrupt delay setting store, registered read port
// Assumes: One write port, one read port, same clock
// Notes:   Holds the delay in 1 ms steps for each interrupt input
`timescale 1ns/1ps
`default_nettype none
module iec_delay_mem #(
  parameter int unsigned DEPTH = 6,
  parameter int unsigned AW    = 3,
  parameter int unsigned DW    = 8
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
    end
    else if (wr_en && (wr_addr < AW'(DEPTH)))
      mem_r[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rd_data <= '0;
    else if (rd_addr < AW'(DEPTH))
      rd_data <= mem_r[rd_addr];
    else
      rd_data <= '0;
  end
endmodule
`default_nettype wire

// File: verif/iec_sensor_model.sv
// Purpose: Sensor and switch model driving the eight input terminals
// Assumes: Active-high levels, changed just after a rising edge
// Notes:   Pulses are always held for the full length asked
`timescale 1ns/1ps
`default_nettype none
module iec_sensor_model (
  // Clock
  input  wire logic       clk_sys,
  // Terminals
  output var  logic [7:0] in_pin
);
  initial in_pin = 8'h00;

  // Hold a level on one terminal
  task automatic level(input int i, input logic v);
    @(posedge clk_sys);
    in_pin[i] <= v;
  endtask

  // ON pulse of n cycles, never cut short
  task automatic pulse(input int i, input int n);
    level(i, 1'b1);
    repeat (n) @(posedge clk_sys);
    in_pin[i] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/iec_tb_top.sv
// Purpose: Self-checking bench for the input edge event capture block
// Assumes: Shortened default filter and delay step parameters
// Notes:   Registers reached over AHB-Lite single word transfers
`timescale 1ns/1ps
`default_nettype none
module iec_tb_top;
  import iec_pkg::*;
  localparam int unsigned DEF_T  = 20;
  localparam int unsigned STEP_T = 10;
  logic        clk_sys;
  logic        sys_rst;
  wire  [7:0]  in_pin;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  iec_freq_t   freq_in;
  logic        irq;
  logic [5:0]  rise_v;
  logic [5:0]  fall_v;
  logic [7:0]  catch_flag;
  logic        soft_mode;
  logic        outputs_off;
  int          fail_count;
  int          n_compared;

  iec_sensor_model u_src (.clk_sys(clk_sys), .in_pin(in_pin));

  iec_top #(.DEF_CYC(DEF_T), .STEP_LEN(STEP_T)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .in_pin(in_pin), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .freq_in(freq_in), .irq(irq),
    .in_rise_vector(rise_v), .in_fall_vector(fall_v), .catch_flag(catch_flag),
    .soft_count_mode(soft_mode), .outputs_off(outputs_off));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        fail_count++;
        stop_test();
      end
      @(posedge clk_sys);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h00000000, d);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    chk({20'h0, catch_flag, soft_mode, outputs_off, irq, hresp}, 32'h0, "reset outs");
    rd(OFF_MASK, d);
    chk(d, RST_MASK, "mask reset");
    rd(OFF_IRQDIS, d);
    chk(d & 32'h3F, RST_IRQDIS, "disable reset");
    rd(OFF_STATUS, d);
    chk(d, 32'h0, "status reset");
    wr(8'h80, 32'hFFFFFFFF);
    rd(8'h80, d);
    chk(d, 32'h0, "unmapped");
  endtask

  task automatic t_edges();
    logic [31:0] d;
    logic [31:0] e;
    wr(OFF_IRQDIS, 32'h0);
    wr(OFF_MASK, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++)
    begin
      e = 32'h1 << (ST_CAT + i);
      if (i < 6)
        e = e | (32'h1 << (ST_RISE + i)) | (32'h1 << (ST_FALL + i));
      u_src.pulse(i, DEF_T + 10);
      cyc(DEF_T + 10);
      chk(32'(catch_flag), 32'h1 << i, "catch out");
      chk({20'h0, fall_v, rise_v}, {20'h0, e[13:8], e[5:0]}, "vectors");
      chk(32'(irq), 32'h1, "irq set");
      rd(OFF_STATUS, d);
      chk(d, e, "status");
      cyc(2);
      chk(32'(irq), 32'h0, "irq clear");
      rd(OFF_STATUS, d);
      chk(d, 32'h0, "one event");
      rd(OFF_CATCH, d);
      chk(d, 32'h1 << i, "catch reg");
    end
  endtask

  task automatic t_disable();
    logic [31:0] d;
    wr(OFF_IRQDIS, 32'h1);
    wr(OFF_MASK, 32'h0);
    u_src.pulse(0, DEF_T + 10);
    u_src.pulse(1, DEF_T + 10);
    cyc(DEF_T + 10);
    chk(32'(irq), 32'h0, "masked irq");
    wr(OFF_MASK, 32'h00003F3F);
    cyc(2);
    chk(32'(irq), 32'h1, "unmasked irq");
    rd(OFF_STATUS, d);
    chk(d & 32'h3F3F, 32'h0202, "disabled input");
    rd(OFF_CATCH, d);
    wr(OFF_IRQDIS, 32'h0);
  endtask

  task automatic catch_try(input int i, input int n, input logic [31:0] e);
    logic [31:0] d;
    u_src.pulse(i, n);
    cyc(10);
    rd(OFF_CATCH, d);
    chk(d, e, "filtered catch");
  endtask

  task automatic t_filters();
    logic [31:0] d;
    wr(OFF_IRQDIS, 32'h00000001);
    wr(OFF_HSCSEL, 32'h000000C1);
    catch_try(1, DEF_T - 8, 32'h0);
    catch_try(0, FAST_FILT_CYC - 20, 32'h0);
    catch_try(0, FAST_FILT_CYC + 20, 32'h1);
    catch_try(6, SLOW_FILT_CYC - 100, 32'h0);
    catch_try(6, SLOW_FILT_CYC + 30, 32'h40);
    cyc(SLOW_FILT_CYC + 10);
    wr(OFF_HSCSEL, 32'h0);
    wr(OFF_IRQDIS, 32'h0);
    rd(OFF_STATUS, d);
  endtask

  task automatic t_delay();
    logic [31:0] d;
    wr(OFF_DELAY + 8'h14, 32'h2);
    u_src.level(5, 1'b1);
    d = 32'h0;
    for (int k = 0; k < 40 && d[5] !== 1'b1; k++)
      rd(OFF_PINS, d);
    chk(d & 32'h20, 32'h20, "filtered level");
    if (d[5] !== 1'b1)
      stop_test();
    rd(OFF_STATUS, d);
    chk(d & 32'h20, 32'h0, "early rise");
    cyc(2 * STEP_T + 5);
    rd(OFF_STATUS, d);
    chk(d & 32'h20, 32'h20, "delayed rise");
    u_src.level(5, 1'b0);
    cyc(DEF_T + 2 * STEP_T + 10);
    rd(OFF_STATUS, d);
    chk(d & 32'h2020, 32'h2000, "delayed fall");
    wr(OFF_DELAY + 8'h14, 32'h0);
  endtask

  task automatic t_freq();
    logic [31:0] d;
    logic [15:0] tot [3] = '{16'h0026, 16'h0029, 16'h002A};
    rd(OFF_STATUS, d);
    for (int j = 0; j < 3; j++)
    begin
      freq_in <= '{total: tot[j], limit: 16'h0029};
      cyc(4);
      rd(OFF_STATUS, d);
      chk(d & (32'h1 << ST_FRQ), (j == 2) ? 32'h1 << ST_FRQ : 32'h0, "freq err");
      rd(OFF_FREQ, d);
      chk(d, {16'h0029, tot[j]}, "freq reg");
    end
    freq_in <= '0;
  endtask

  task automatic t_control();
    logic [31:0] d;
    rd(OFF_STATUS, d);
    u_src.pulse(2, DEF_T + 10);
    cyc(DEF_T + 10);
    wr(OFF_CONTROL, 32'h1);
    cyc(2);
    chk(32'(soft_mode), 32'h1, "software mode");
    chk(32'(irq), 32'h1, "irq pending");
    chk(32'(rise_v), 32'h4, "rise vector");
    wr(OFF_CONTROL, 32'h3);
    cyc(2);
    chk({30'h0, outputs_off, irq}, 32'h2, "watchdog off");
    chk({12'h0, catch_flag, fall_v, rise_v}, 32'h0, "forced off");
    sys_rst <= 1'b1;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(1);
    chk({30'h0, outputs_off, soft_mode}, 32'h0, "reset clears");
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  initial
  begin
    fail_count = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    freq_in = '0;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(1);
    t_reset();
    t_edges();
    t_disable();
    t_filters();
    t_delay();
    t_freq();
    t_control();
    stop_test();
  end
endmodule
`default_nettype wire
